// [src/char_lcd_defs.vh]
// constants for the character display host port
// How it works
// - interface pins pick serial/parallel; bit picks width
// - instruction holder and data holder, both 8-bit
// - written data byte moves itself into memory
// - after data read, next byte prefetched automatically
// - instruction holder is write only
// - select and read/write decode four bus cycles
// - busy high during operation, instructions refused
// - busy readback only in parallel modes
// - display memory holds 128 character codes, 80 in the map
// - character code selects one of 256 glyphs
// - one-line display starts at first position
// - two-line heads; line ends not adjacent
// - 16x2 shows 00-0f and 40-4f
// - display shift moves the shown addresses
// - address counter steps by one each access
// - address setting instruction loads address counter
// - status read gives address counter on 0-6
// - cursor on/off and blink logic
// - function set holds width, lines and font bits
// - direction bit one increments, zero decrements
`ifndef CHAR_LCD_DEFS_VH
`define CHAR_LCD_DEFS_VH
`define IF_PARALLEL 2'h0
`define LINE2_BASE 7'h40
`define LINE_LEN 7'h28
`define DISP_SIZE 7'h50
`define CLK_MHZ 20
`define SHORT_OP_NS 18500
`define LONG_OP_NS 760000
`define SHORT_OP_CYC ((`SHORT_OP_NS * `CLK_MHZ + 999) / 1000)
`define LONG_OP_CYC ((`LONG_OP_NS * `CLK_MHZ + 999) / 1000)
`define BLANK_CODE 8'h20
`endif

// [src/char_lcd_host_port.v]
// host-side parallel port of a character display controller
`include "char_lcd_defs.vh"
module char_lcd_host_port #(
  parameter LONG_OP_CYCLES = `LONG_OP_CYC,
  parameter SHORT_OP_CYCLES = `SHORT_OP_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // interface select straps
  input wire interface_select_pin_hi,
  input wire interface_select_pin_lo,
  // host bus
  input wire enable,
  input wire register_select,
  input wire read_write,
  input wire [7:0] db_in,
  output reg [7:0] db_out,
  output wire db_oe,
  // display side
  input wire [6:0] view_pos,
  input wire view_line,
  output reg [7:0] view_code,
  output reg [6:0] view_addr,
  output reg cursor_here,
  output reg blink_on,
  output reg cursor_on,
  output reg display_on,
  output reg lines_two,
  output reg font_tall,
  output reg busy_indicator
);
  localparam S_IDLE = 3'b001;
  localparam S_BUSY = 3'b010;
  localparam S_XFER = 3'b100;

  reg [7:0] display_char_memory [0:127];
  reg [7:0] user_glyph_memory [0:63];
  reg [7:0] instruction_holder_r;
  reg [7:0] data_holder_r;
  reg [6:0] address_counter_r;
  reg use_glyph_r;
  reg dir_inc_r;
  reg shift_en_r;
  reg bus_width_bit_r;
  reg [6:0] shift_r;
  reg [2:0] state_r;
  reg [19:0] cnt_r;
  reg nib_low_r;
  reg [3:0] hi_nib_r;
  reg en_d_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [6:0] clr_idx_r;
  reg clearing_r;
  reg [7:0] rd_byte;
  wire parallel;
  wire strobe;
  wire byte_done;
  wire [7:0] byte_in;
  wire cyc_instr;
  wire cyc_wdata;
  wire cyc_rdata;
  wire [7:0] op_kind;
  wire [6:0] ac_next;

  // steps an address, wrapping in the two-line map
  function [6:0] step_addr;
    input [6:0] a;
    input up;
    input two;
    input glyph;
    begin
      if (glyph)
        step_addr = up ? ((a + 7'h01) & 7'h3f) : ((a - 7'h01) & 7'h3f);
      else if (two) begin
        if (up)
          step_addr = (a == 7'h27) ? `LINE2_BASE : (a == 7'h67) ? 7'h00 : a + 7'h01;
        else
          step_addr = (a == 7'h00) ? 7'h67 : (a == `LINE2_BASE) ? 7'h27 : a - 7'h01;
      end else
        step_addr = up ? ((a == 7'h4f) ? 7'h00 : a + 7'h01) : ((a == 7'h00) ? 7'h4f : a - 7'h01);
    end
  endfunction

  // keeps the display shift inside one lap of memory
  function [6:0] shift_step;
    input [6:0] s;
    input left;
    begin
      if (left)
        shift_step = (s == `DISP_SIZE - 7'h01) ? 7'h00 : s + 7'h01;
      else
        shift_step = (s == 7'h00) ? `DISP_SIZE - 7'h01 : s - 7'h01;
    end
  endfunction

  // memory address shown at a scan position
  function [6:0] view_map;
    input [6:0] pos;
    input [6:0] s;
    input two;
    input line;
    reg [7:0] sum;
    reg [7:0] lap;
    begin
      sum = {1'b0, pos} + {1'b0, s};
      if (two) begin
        lap = sum % {1'b0, `LINE_LEN};
        view_map = lap[6:0] + (line ? `LINE2_BASE : 7'h00);
      end else begin
        lap = sum % {1'b0, `DISP_SIZE};
        view_map = lap[6:0];
      end
    end
  endfunction

  // byte held at a memory address
  function [7:0] fetch_byte;
    input [6:0] a;
    input glyph;
    begin
      fetch_byte = glyph ? user_glyph_memory[a[5:0]] : display_char_memory[a];
    end
  endfunction

  // one-hot class of an instruction code
  function [7:0] op_class;
    input [7:0] c;
    begin
      casez (c)
        8'b1???????: op_class = 8'h80;
        8'b01??????: op_class = 8'h40;
        8'b001?????: op_class = 8'h20;
        8'b0001????: op_class = 8'h10;
        8'b00001???: op_class = 8'h08;
        8'b000001??: op_class = 8'h04;
        8'b0000001?: op_class = 8'h02;
        8'b00000001: op_class = 8'h02;
        default: op_class = 8'h01;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // bus cycle decode
  assign cyc_instr = byte_done && !register_select && !read_write;
  assign cyc_wdata = byte_done && register_select && !read_write;
  assign cyc_rdata = byte_done && register_select && read_write;
  assign op_kind = op_class(byte_in);
  assign ac_next = step_addr(address_counter_r, dir_inc_r, lines_two, use_glyph_r);

  assign parallel = {interface_select_pin_hi, interface_select_pin_lo} == `IF_PARALLEL;
  assign strobe = parallel && enable && !en_d_r;
  assign byte_done = strobe && (bus_width_bit_r || nib_low_r);
  assign byte_in = bus_width_bit_r ? db_in : {hi_nib_r, db_in[7:4]};
  assign db_oe = parallel && enable && read_write;

  ////////////////////////////////////////////////////////////
  // read mux
  always @* begin
    rd_byte = data_holder_r;
    if (!register_select)
      rd_byte = {busy_indicator, address_counter_r};
  end

  always @(posedge mclk) begin
    if (rst) begin
      db_out <= 8'h00;
    end else if (bus_width_bit_r || !nib_low_r) begin
      db_out <= rd_byte;
    end else begin
      db_out <= {rd_byte[3:0], 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////
  // bus cycles, instructions and transfers
  always @(posedge mclk) begin
    if (rst) begin
      instruction_holder_r <= 8'h00;
      data_holder_r <= 8'h00;
      address_counter_r <= 7'h00;
      use_glyph_r <= 1'b0;
      dir_inc_r <= 1'b1;
      shift_en_r <= 1'b0;
      bus_width_bit_r <= 1'b1;
      lines_two <= 1'b0;
      font_tall <= 1'b0;
      display_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      shift_r <= 7'h00;
      state_r <= S_IDLE;
      cnt_r <= 20'h00000;
      nib_low_r <= 1'b0;
      hi_nib_r <= 4'h0;
      en_d_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      clearing_r <= 1'b0;
      clr_idx_r <= 7'h00;
      busy_indicator <= 1'b0;
    end else begin
      en_d_r <= enable;
      if (strobe && !bus_width_bit_r) begin
        nib_low_r <= !nib_low_r;
        if (!read_write)
          hi_nib_r <= db_in[7:4];
      end
      case (state_r)
        S_IDLE: begin
          if (cyc_wdata) begin
            data_holder_r <= byte_in;
            wr_pend_r <= 1'b1;
            state_r <= S_XFER;
            busy_indicator <= 1'b1;
          end else if (cyc_rdata) begin
            rd_pend_r <= 1'b1;
            state_r <= S_XFER;
            busy_indicator <= 1'b1;
          end else if (cyc_instr) begin
            instruction_holder_r <= byte_in;
            busy_indicator <= 1'b1;
            state_r <= S_BUSY;
            cnt_r <= SHORT_OP_CYCLES[19:0];
            case (op_kind)
              8'h80: begin
                address_counter_r <= byte_in[6:0];
                use_glyph_r <= 1'b0;
                data_holder_r <= fetch_byte(byte_in[6:0], 1'b0);
              end
              8'h40: begin
                address_counter_r <= {1'b0, byte_in[5:0]};
                use_glyph_r <= 1'b1;
                data_holder_r <= fetch_byte({1'b0, byte_in[5:0]}, 1'b1);
              end
              8'h20: begin
                bus_width_bit_r <= byte_in[4];
                lines_two <= byte_in[3];
                font_tall <= byte_in[2];
                nib_low_r <= 1'b0;
              end
              8'h10: begin
                if (byte_in[3])
                  shift_r <= shift_step(shift_r, !byte_in[2]);
                else
                  address_counter_r <= step_addr(address_counter_r, byte_in[2], lines_two, use_glyph_r);
              end
              8'h08: begin
                display_on <= byte_in[2];
                cursor_on <= byte_in[1];
                blink_on <= byte_in[0];
              end
              8'h04: begin
                dir_inc_r <= byte_in[1];
                shift_en_r <= byte_in[0];
              end
              8'h02: begin
                address_counter_r <= 7'h00;
                use_glyph_r <= 1'b0;
                shift_r <= 7'h00;
                cnt_r <= LONG_OP_CYCLES[19:0];
                if (byte_in[0]) begin
                  dir_inc_r <= 1'b1;
                  clearing_r <= 1'b1;
                  clr_idx_r <= 7'h00;
                end
              end
              default: begin
                cnt_r <= SHORT_OP_CYCLES[19:0];
              end
            endcase
          end
        end
        S_XFER: begin
          if (wr_pend_r) begin
            if (use_glyph_r)
              user_glyph_memory[address_counter_r[5:0]] <= data_holder_r;
            else
              display_char_memory[address_counter_r] <= data_holder_r;
            if (shift_en_r && !use_glyph_r)
              shift_r <= shift_step(shift_r, dir_inc_r);
          end else begin
            data_holder_r <= fetch_byte(ac_next, use_glyph_r);
          end
          address_counter_r <= ac_next;
          wr_pend_r <= 1'b0;
          rd_pend_r <= 1'b0;
          state_r <= S_BUSY;
          cnt_r <= SHORT_OP_CYCLES[19:0];
        end
        S_BUSY: begin
          if (clearing_r) begin
            display_char_memory[clr_idx_r] <= `BLANK_CODE;
            clr_idx_r <= clr_idx_r + 7'h01;
            if (clr_idx_r == 7'h7f)
              clearing_r <= 1'b0;
          end
          // clear keeps busy until every entry is blanked
          if (cnt_r <= 20'h00001 && !clearing_r) begin
            state_r <= S_IDLE;
            busy_indicator <= 1'b0;
          end else if (cnt_r > 20'h00001) begin
            cnt_r <= cnt_r - 20'h00001;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // display fetch with shift and line mapping
  always @(posedge mclk) begin
    if (rst) begin
      view_addr <= 7'h00;
      view_code <= 8'h00;
      cursor_here <= 1'b0;
    end else begin
      view_addr <= view_map(view_pos, shift_r, lines_two, view_line);
      view_code <= display_char_memory[view_addr];
      cursor_here <= cursor_on && !use_glyph_r && view_addr == address_counter_r;
    end
  end
endmodule

// [testbench/host_model.sv]
// host processor model driving the parallel bus
module host_model (
  // clock
  input wire mclk,
  // bus
  input wire [7:0] db_out,
  output reg enable,
  output reg register_select,
  output reg read_write,
  output reg [7:0] db_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {enable, register_select, read_write, db_in} = 11'h0;
  // one strobe; q is read data registered at the take edge
  task xfer(input rs, input rw, input [7:0] d, output [7:0] q);
    @(posedge mclk) #2;
    {register_select, read_write, db_in} = {rs, rw, d};
    enable = 1;
    @(posedge mclk) #2 q = db_out;
    @(posedge mclk) #2;
    enable = 0;
    db_in = ~db_in;
  endtask
  task poll(input two);
    reg [7:0] s;
    reg [7:0] t;
    for (int i = 0; i < 40; i++) begin
      xfer(0, 1, 8'h00, s);
      if (two) xfer(0, 1, 8'h00, t);
      if (s[7] === 1'b0) break;
    end
  endtask
  task put(input rs, input [7:0] d, input two);
    reg [7:0] s;
    if (two) begin
      xfer(rs, 0, {d[7:4], 4'h0}, s);
      xfer(rs, 0, {d[3:0], 4'h0}, s);
    end else begin
      xfer(rs, 0, d, s);
    end
    poll(two);
  endtask
endmodule

// [testbench/lcd_port_checker.sv]
// assertions on the host port of the character display
module lcd_port_checker (
  // clock and reset
  input wire mclk,
  input wire rst,
  // straps and bus
  input wire interface_select_pin_hi,
  input wire interface_select_pin_lo,
  input wire enable,
  input wire register_select,
  input wire read_write,
  input wire [7:0] db_in,
  input wire db_oe,
  input wire busy_indicator
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire par = !interface_select_pin_hi && !interface_select_pin_lo;
  reg wide_r;
  // bus width seen by the checker
  always @(posedge mclk) begin
    if (rst) begin
      wide_r <= 1'b1;
    end else if (wide_r && par && $rose(enable) && !busy_indicator && !register_select && !read_write
        && db_in[7:5] == 3'h1) begin
      wide_r <= db_in[4];
    end
  end
  sequence take_s;
    $rose(enable) && par && !busy_indicator;
  endsequence
  sequence stand_s;
    busy_indicator [*8];
  endsequence
  ////////////////////////////////////////////////////////////
  oe_decode_a: assert property (db_oe == (par && enable && read_write))
    else $error("bus drive enable wrong");
  serial_quiet_a: assert property (!par |-> !db_oe)
    else $error("bus driven in serial mode");
  instr_busy_a: assert property (take_s ##0 (wide_r && !register_select && !read_write) |=> busy_indicator)
    else $error("busy missing after instruction");
  data_busy_a: assert property (take_s ##0 (wide_r && register_select && !read_write) |=> busy_indicator)
    else $error("busy missing after data write");
  busy_stand_a: assert property ($rose(busy_indicator) |-> stand_s)
    else $error("busy dropped early");
  busy_clear_a: assert property ($rose(busy_indicator) |-> ##[8:9] !busy_indicator)
    else $error("busy never cleared");
  status_idle_a: assert property (take_s ##0 (!register_select && read_write) |=> !busy_indicator)
    else $error("status read started work");
  serial_ignore_a: assert property ($rose(enable) && !par && !busy_indicator |=> !busy_indicator)
    else $error("serial mode took a strobe");
endmodule

// [testbench/tb_char_lcd_host_port.sv]
// testbench for the character display host port
module tb_char_lcd_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  reg mclk = 0, rst = 1, sel_hi = 0, sel_lo = 0;
  wire enable, register_select, read_write, db_oe, busy_indicator;
  wire blink_on, cursor_on, display_on, lines_two;
  wire [7:0] db_in, db_out;
  reg [6:0] view_pos = 7'h00;
  reg view_line = 0;
  wire [6:0] view_addr;
  wire [7:0] view_code;
  wire cursor_here, font_tall;
  reg [7:0] q;
  int mismatches = 0, n_tests = 0;
  char_lcd_host_port #(.LONG_OP_CYCLES(8), .SHORT_OP_CYCLES(8)) uut (.mclk(mclk), .rst(rst),
    .interface_select_pin_hi(sel_hi), .interface_select_pin_lo(sel_lo), .enable(enable),
    .register_select(register_select), .read_write(read_write), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe), .view_pos(view_pos), .view_line(view_line), .view_code(view_code), .view_addr(view_addr),
    .cursor_here(cursor_here), .blink_on(blink_on), .cursor_on(cursor_on), .display_on(display_on),
    .lines_two(lines_two), .font_tall(font_tall), .busy_indicator(busy_indicator));
  host_model hst (.mclk(mclk), .db_out(db_out), .enable(enable), .register_select(register_select),
    .read_write(read_write), .db_in(db_in));
  always #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task check(input [7:0] seen, input [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task t_basic;
    check(busy_indicator, 0);
    hst.put(0, 8'h0f, 0);
    check({display_on, cursor_on, blink_on}, 3'h7);
  endtask
  task t_addr;
    hst.put(0, 8'h85, 0);
    hst.xfer(0, 1, 0, q);
    check(q, 8'h05);
    hst.xfer(1, 0, 8'h41, q);
    check(busy_indicator, 1);
    hst.xfer(0, 0, 8'ha0, q);
    hst.poll(0);
    hst.put(1, 8'h42, 0);
    hst.xfer(0, 1, 0, q);
    check(q, 8'h07);
    hst.put(0, 8'h85, 0);
    hst.xfer(1, 1, 0, q);
    check(q, 8'h41);
    hst.poll(0);
    hst.xfer(1, 1, 0, q);
    check(q, 8'h42);
    hst.poll(0);
    hst.put(0, 8'h04, 0);
    hst.put(1, 8'h43, 0);
    hst.xfer(0, 1, 0, q);
    check(q, 8'h06);
  endtask
  task t_serial;
    sel_hi = 1;
    hst.xfer(1, 0, 8'h55, q);
    check(busy_indicator, 0);
    sel_hi = 0;
    hst.xfer(0, 1, 0, q);
    check(q, 8'h06);
  endtask
  task t_nibble;
    hst.xfer(0, 0, 8'h28, q);
    hst.poll(1);
    check(lines_two, 1);
    hst.put(0, 8'h90, 1);
    hst.xfer(0, 1, 0, q);
    check(q[7:4], 4'h1);
    hst.xfer(0, 1, 0, q);
    check(q[7:4], 4'h0);
  endtask
  task t_view;
    hst.put(0, 8'h2c, 1);
    check(font_tall, 1);
    view_pos = 7'h0f;
    view_line = 1;
    repeat (2) @(posedge mclk);
    #2 check(view_addr, 8'h4f);
    hst.put(0, 8'h18, 1);
    check(view_addr, 8'h50);
    view_pos = 7'h00;
    view_line = 0;
    hst.put(0, 8'h1c, 1);
    hst.put(0, 8'h1c, 1);
    check(view_addr, 8'h27);
    hst.put(0, 8'h02, 1);
    check(cursor_here, 1);
    hst.put(1, 8'h5a, 1);
    check(view_code, 8'h5a);
    check(cursor_here, 0);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    #2 rst = 0;
    t_basic;
    t_addr;
    t_serial;
    t_nibble;
    t_view;
    close_out;
  end
  initial begin
    #300000;
    mismatches++;
    close_out;
  end
endmodule
bind char_lcd_host_port lcd_port_checker chk (.mclk, .rst, .interface_select_pin_hi, .interface_select_pin_lo,
  .enable, .register_select, .read_write, .db_in, .db_oe, .busy_indicator);
